// ---- logic/scr_consts.svh ----
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH

// Register byte offsets.
`define SCR_OFS_CTRL 8'h00
`define SCR_OFS_SMMR 8'h04
`define SCR_OFS_MODE 8'h08
`define SCR_OFS_STAT 8'h14
`define SCR_OFS_PWR 8'h1C
`define SCR_OFS_WPMR 8'hD4

// Keys.
`define SCR_KEY_VALUE 8'hA5
`define SCR_WP_KEY 24'h525443

// Control register fields.
`define SCR_CTRL_MDRC 5
`define SCR_CTRL_XTAL 3
`define SCR_CTRL_ZERO 2

// Supply monitor mode register field.
`define SCR_SMMR_THR 23

// Mode register fields.
`define SCR_MODE_FAST 22
`define SCR_MODE_BYP 20
`define SCR_MODE_DIS 13
`define SCR_MODE_RSTEN 12

// Status and power register fields.
`define SCR_STAT_TDSRC 7
`define SCR_STAT_EVT 3
`define SCR_PWR_MDSRC 18

// Protection register field.
`define SCR_WP_EN 0

// Reset values of stored fields.
`define SCR_MODE_RESET 32'h00004A00
`define SCR_WRITE_PROTECT_ENABLE_RESET 1'b0

// Start-up lengths in slow RC periods, and loss and clear delays in slow periods.
`define SCR_STARTUP_SLOW 16'hCE40
`define SCR_STARTUP_FAST 16'h0001
`define SCR_LOSS_TICKS 2'h2
`define SCR_CLR_TICKS 2'h2

`endif

// ---- logic/scr_pkg.sv ----
package scr_pkg;

   // Timing-domain clock source sequence, one-hot.
   typedef enum logic [2:0] {
      SCR_TD_RC = 3'h1,
      SCR_TD_STARTUP = 3'h2,
      SCR_TD_XTAL = 3'h4
   } scr_td_e;

   // Whole state of the supply controller register block.
   typedef struct packed {
      logic write_protect_enable;
      logic mdrc;
      logic thr;
      logic fast;
      logic bypass;
      logic cmdis;
      logic rsten;
      scr_td_e td;
      logic [15:0] stup_cnt;
      logic slow_q;
      logic valid_q;
      logic [1:0] lost_cnt;
      logic crst_n;
      logic rst_tick;
      logic evt;
      logic [1:0] clr_cnt;
      logic xtal_out;
      logic byp_out;
      logic mon_en;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } scr_state_s;

endpackage : scr_pkg

// ---- logic/scr_supply_regs.sv ----
`timescale 1ns/1ns
`include "scr_consts.svh"

module scr_supply_regs #(
   parameter logic [15:0] STARTUP_SLOW = `SCR_STARTUP_SLOW
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Slow RC oscillator and core supply monitor cell.
   input wire logic slow_rc_clk,
   input wire logic core_monitor_valid,
   // Clock and supply controls.
   output logic monitor_clk_rc_select,
   output logic timing_clk_crystal,
   output logic osc_bypass_a,
   output logic core_monitor_enable,
   output logic core_reset_n
);

   // Current and next state.
   scr_pkg::scr_state_s st;
   scr_pkg::scr_state_s next_st;

   // Decode of an address onto one mapped register.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // True when an address belongs to the block at all.
   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, `SCR_OFS_CTRL) | hit(a, `SCR_OFS_SMMR) | hit(a, `SCR_OFS_MODE) |
               hit(a, `SCR_OFS_STAT) | hit(a, `SCR_OFS_PWR) | hit(a, `SCR_OFS_WPMR);
   endfunction : mapped

   // Completed access and derived strobes.
   logic acc;
   logic wr;
   logic key_ok;
   logic slow_tick;
   logic stat_rd;

   // A transfer completes at the edge where the access phase sees pready.
   always_comb begin
      acc = psel & penable & st.pready;
      wr = acc & pwrite;
      key_ok = (pwdata[31:24] == `SCR_KEY_VALUE);
      slow_tick = slow_rc_clk & ~st.slow_q;
      stat_rd = acc & ~pwrite & hit(paddr, `SCR_OFS_STAT);
   end

   // Next-state logic for the whole block.
   always_comb begin
      next_st = st;
      next_st.slow_q = slow_rc_clk;
      next_st.valid_q = core_monitor_valid;
      // No wait state: pready rises in the first access cycle and falls after it.
      next_st.pready = psel & ~penable;
      next_st.pslverr = psel & ~penable & ~mapped(paddr);
      next_st.prdata = 32'h00000000;
      // Read data are captured during setup; unlisted bits stay zero.
      if (psel & ~penable & ~pwrite) begin
         // Control reads zero and keys are never returned.
         if (hit(paddr, `SCR_OFS_SMMR)) begin
            next_st.prdata[`SCR_SMMR_THR] = st.thr;
         end
         if (hit(paddr, `SCR_OFS_MODE)) begin
            next_st.prdata[`SCR_MODE_FAST] = st.fast;
            next_st.prdata[`SCR_MODE_BYP] = st.bypass;
            next_st.prdata[`SCR_MODE_DIS] = st.cmdis;
            next_st.prdata[`SCR_MODE_RSTEN] = st.rsten;
         end
         if (hit(paddr, `SCR_OFS_STAT)) begin
            next_st.prdata[`SCR_STAT_TDSRC] = (st.td == scr_pkg::SCR_TD_XTAL);
            next_st.prdata[`SCR_STAT_EVT] = st.evt;
         end
         // Power bit 18 always reads zero: the monitor clock has one source.
         if (hit(paddr, `SCR_OFS_PWR)) begin
            next_st.prdata[`SCR_PWR_MDSRC] = 1'b0;
         end
         if (hit(paddr, `SCR_OFS_WPMR)) begin
            next_st.prdata[`SCR_WP_EN] = st.write_protect_enable;
         end
      end
      // Protection register: the enable changes only under the full key.
      if (wr & hit(paddr, `SCR_OFS_WPMR) & (pwdata[31:8] == `SCR_WP_KEY)) begin
         next_st.write_protect_enable = pwdata[`SCR_WP_EN];
      end
      // Supply registers ignore all writes while protection is on.
      if (wr & ~st.write_protect_enable) begin
         if (hit(paddr, `SCR_OFS_SMMR)) begin
            // Threshold select is stored as written; software keeps it zero.
            next_st.thr = pwdata[`SCR_SMMR_THR];
         end
         if (hit(paddr, `SCR_OFS_MODE) & key_ok) begin
            next_st.fast = pwdata[`SCR_MODE_FAST];
            next_st.bypass = pwdata[`SCR_MODE_BYP];
            next_st.cmdis = pwdata[`SCR_MODE_DIS];
            next_st.rsten = pwdata[`SCR_MODE_RSTEN];
         end
         // Control bit 2 is not decoded; writing one there is unsupported.
         if (hit(paddr, `SCR_OFS_CTRL) & key_ok) begin
            if (pwdata[`SCR_CTRL_MDRC]) begin
               next_st.mdrc = 1'b1;
            end
            if (pwdata[`SCR_CTRL_XTAL] & (st.td == scr_pkg::SCR_TD_RC)) begin
               next_st.td = scr_pkg::SCR_TD_STARTUP;
               next_st.stup_cnt = st.fast ? `SCR_STARTUP_FAST : STARTUP_SLOW;
            end
         end
      end
      // Start-up count runs on slow RC periods; the source flips only at its end.
      case (st.td)
         scr_pkg::SCR_TD_RC: begin
         end
         scr_pkg::SCR_TD_STARTUP: begin
            if (slow_tick) begin
               if (st.stup_cnt <= 16'h0001) begin
                  next_st.td = scr_pkg::SCR_TD_XTAL;
               end else begin
                  next_st.stup_cnt = st.stup_cnt - 16'h0001;
               end
            end
         end
         scr_pkg::SCR_TD_XTAL: begin
            // No write leads back; only presetn does.
            next_st.td = scr_pkg::SCR_TD_XTAL;
         end
         default: begin
            next_st.td = scr_pkg::SCR_TD_RC;
         end
      endcase
      next_st.xtal_out = (next_st.td == scr_pkg::SCR_TD_XTAL);
      next_st.byp_out = st.bypass & (next_st.td != scr_pkg::SCR_TD_RC);
      next_st.mon_en = ~st.cmdis;
      // Loss of valid is timed in slow ticks so a short dip is filtered.
      if (core_monitor_valid | st.cmdis) begin
         next_st.lost_cnt = 2'h0;
      end else if (slow_tick & (st.lost_cnt != `SCR_LOSS_TICKS)) begin
         next_st.lost_cnt = st.lost_cnt + 2'h1;
      end
      // Reset asserts after a loss of more than one slow period when enabled.
      if (st.rsten & (st.lost_cnt == `SCR_LOSS_TICKS)) begin
         next_st.crst_n = 1'b0;
         next_st.rst_tick = 1'b0;
      end else if (~st.crst_n) begin
         if (slow_tick) begin
            next_st.rst_tick = 1'b1;
         end
         // Release needs one full slow tick low and a valid supply.
         if (st.rst_tick & core_monitor_valid) begin
            next_st.crst_n = 1'b1;
         end
      end
      // Status clear is delayed two slow ticks after the read.
      if (stat_rd) begin
         next_st.clr_cnt = `SCR_CLR_TICKS;
      end else if (slow_tick & (st.clr_cnt != 2'h0)) begin
         next_st.clr_cnt = st.clr_cnt - 2'h1;
         if (st.clr_cnt == 2'h1) begin
            next_st.evt = 1'b0;
         end
      end
      // A falling valid is one event; a steady low adds none. Set beats clear.
      if (st.valid_q & ~core_monitor_valid & ~st.cmdis) begin
         next_st.evt = 1'b1;
      end
   end

   // Register the whole state; the core reset is held asserted in reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.write_protect_enable <= `SCR_WRITE_PROTECT_ENABLE_RESET;
         st.mdrc <= 1'b1;
         st.thr <= 1'b0;
         st.td <= scr_pkg::SCR_TD_RC;
         st.mon_en <= 1'b1;
         st.valid_q <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Every output comes straight from a state flop.
   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign monitor_clk_rc_select = st.mdrc;
   assign timing_clk_crystal = st.xtal_out;
   assign osc_bypass_a = st.byp_out;
   assign core_monitor_enable = st.mon_en;
   assign core_reset_n = st.crst_n;

   // Unprotected control write that asks for the crystal, with any key.
   sequence s_xtal_req;
      wr & ~st.write_protect_enable & hit(paddr, `SCR_OFS_CTRL) & pwdata[`SCR_CTRL_XTAL];
   endsequence

   // A wrong key leaves the source machine idle.
   property p_bad_key;
      @(posedge pclk) disable iff (!presetn)
      s_xtal_req and (!key_ok && st.td == scr_pkg::SCR_TD_RC) |=> st.td == scr_pkg::SCR_TD_RC;
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("Unkeyed control write acted.");

   // A good key starts the start-up count.
   property p_xtal_start;
      @(posedge pclk) disable iff (!presetn)
      s_xtal_req and (key_ok && st.td == scr_pkg::SCR_TD_RC) |=> st.td == scr_pkg::SCR_TD_STARTUP;
   endproperty
   a_xtal_start: assert property (p_xtal_start) else $error("Crystal start missed.");

   // Protected mode register keeps its reset enable and disable fields.
   property p_protect;
      @(posedge pclk) disable iff (!presetn)
      st.write_protect_enable && wr && hit(paddr, `SCR_OFS_MODE) |=> $stable(st.rsten) && $stable(st.cmdis);
   endproperty
   a_protect: assert property (p_protect) else $error("Protected write took effect.");

   // Fast start-up ends on the first slow tick.
   property p_fast;
      @(posedge pclk) disable iff (!presetn)
      st.td == scr_pkg::SCR_TD_STARTUP && st.stup_cnt == 16'h0001 && slow_tick
      |=> st.td == scr_pkg::SCR_TD_XTAL ##1 timing_clk_crystal;
   endproperty
   a_fast: assert property (p_fast) else $error("Start-up end not seen.");

   // The crystal source never reverts.
   property p_stay;
      @(posedge pclk) disable iff (!presetn)
      st.td == scr_pkg::SCR_TD_XTAL |=> st.td == scr_pkg::SCR_TD_XTAL && timing_clk_crystal;
   endproperty
   a_stay: assert property (p_stay) else $error("Crystal source reverted.");

   // A falling valid with the monitor on raises the event flag.
   property p_event;
      @(posedge pclk) disable iff (!presetn)
      st.valid_q && !core_monitor_valid && !st.cmdis |=> st.evt;
   endproperty
   a_event: assert property (p_event) else $error("Monitor event lost.");

   // Core reset only falls when the reset enable is on.
   property p_rst_en;
      @(posedge pclk) disable iff (!presetn)
      $fell(core_reset_n) |-> $past(st.rsten);
   endproperty
   a_rst_en: assert property (p_rst_en) else $error("Reset without enable.");

   // Protection and power reads never show key or reserved bits.
   property p_read_zero;
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && (hit(paddr, `SCR_OFS_WPMR) || hit(paddr, `SCR_OFS_PWR))
      |=> prdata[31:1] == 31'h00000000;
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("Key or reserved bits read.");

   // The event flag survives a status read until the slow ticks pass.
   property p_clr_delay;
      @(posedge pclk) disable iff (!presetn)
      stat_rd && st.evt |=> st.evt;
   endproperty
   a_clr_delay: assert property (p_clr_delay) else $error("Status cleared early.");

   // An enabled reset with a loss long enough to act on.
   sequence s_loss;
      st.rsten && st.lost_cnt == `SCR_LOSS_TICKS;
   endsequence

   // A mode write with a wrong key leaves every mode field as it was.
   property p_mode_key;
      @(posedge pclk) disable iff (!presetn)
      wr && hit(paddr, `SCR_OFS_MODE) && !key_ok
      |=> $stable(st.fast) && $stable(st.bypass) && $stable(st.rsten) && $stable(st.cmdis);
   endproperty
   a_mode_key: assert property (p_mode_key) else $error("Unkeyed mode write acted.");

   // A keyed request for the RC monitor clock leaves the pin on RC.
   property p_mdrc_set;
      @(posedge pclk) disable iff (!presetn)
      wr && !st.write_protect_enable && hit(paddr, `SCR_OFS_CTRL) && key_ok && pwdata[`SCR_CTRL_MDRC]
      |=> monitor_clk_rc_select;
   endproperty
   a_mdrc_set: assert property (p_mdrc_set) else $error("Monitor clock not on RC.");

   // A set disable bit turns the monitor off one cycle later.
   property p_mon_en;
      @(posedge pclk) disable iff (!presetn)
      st.cmdis |=> !core_monitor_enable;
   endproperty
   a_mon_en: assert property (p_mon_en) else $error("Monitor left enabled.");

   // Bypass never reaches the pin while the timing clock is still on RC.
   property p_byp_rc;
      @(posedge pclk) disable iff (!presetn)
      st.td == scr_pkg::SCR_TD_RC |-> !osc_bypass_a;
   endproperty
   a_byp_rc: assert property (p_byp_rc) else $error("Bypass before selection.");

   // With no clear pending the event flag is sticky.
   property p_evt_hold;
      @(posedge pclk) disable iff (!presetn)
      st.evt && st.clr_cnt == 2'h0 |=> st.evt;
   endproperty
   a_evt_hold: assert property (p_evt_hold) else $error("Event flag dropped.");

   // A supply that stays low adds no further event.
   property p_no_repeat;
      @(posedge pclk) disable iff (!presetn)
      !st.valid_q && !core_monitor_valid && !st.evt |=> !st.evt;
   endproperty
   a_no_repeat: assert property (p_no_repeat) else $error("Repeated event.");

   // The second slow tick after a read clears the flag unless a new event lands.
   property p_clear_lands;
      @(posedge pclk) disable iff (!presetn)
      slow_tick && st.clr_cnt == 2'h1 && !stat_rd && !(st.valid_q && !core_monitor_valid)
      |=> !st.evt;
   endproperty
   a_clear_lands: assert property (p_clear_lands) else $error("Status clear missed.");

   // A protection write without the full key keeps the enable.
   property p_wp_key;
      @(posedge pclk) disable iff (!presetn)
      wr && hit(paddr, `SCR_OFS_WPMR) && pwdata[31:8] != `SCR_WP_KEY |=> $stable(st.write_protect_enable);
   endproperty
   a_wp_key: assert property (p_wp_key) else $error("Unkeyed protection write.");

   // An enabled, long enough loss pulls the core reset low.
   property p_rst_assert;
      @(posedge pclk) disable iff (!presetn)
      s_loss |=> !core_reset_n;
   endproperty
   a_rst_assert: assert property (p_rst_assert) else $error("Reset not asserted.");

   // After a slow tick low, a valid supply releases the core reset.
   property p_rst_release;
      @(posedge pclk) disable iff (!presetn)
      !core_reset_n && st.rst_tick && core_monitor_valid && !(st.rsten && st.lost_cnt == 2'h2)
      |=> core_reset_n;
   endproperty
   a_rst_release: assert property (p_rst_release) else $error("Reset not released.");

   // An error answer only comes with the ready of its transfer.
   property p_pslverr;
      @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready;
   endproperty
   a_pslverr: assert property (p_pslverr) else $error("Error without ready.");

endmodule : scr_supply_regs

// ---- test/tb.sv ----
`timescale 1ns/1ns
`include "scr_consts.svh"

module tb;
   // Clock, reset and supply monitor inputs.
   logic pclk = 1'b0;
   // Reset starts released so that the first pulse makes a falling edge.
   logic presetn = 1'b1;
   logic slow_rc_clk = 1'b0;
   logic core_monitor_valid = 1'b1;
   // APB master signals.
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   // Clock and supply controls driven by the block.
   logic rc_sel;
   logic xtal;
   logic byp;
   logic mon_en;
   logic core_rst_n;
   // Scoreboard counters.
   int err_total = 0;
   int tests_run = 0;
   // Divider for the slow tick source.
   int div = 0;

   // A short start-up count keeps the slow start-up case brief.
   scr_supply_regs #(.STARTUP_SLOW(16'h0004)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .slow_rc_clk(slow_rc_clk), .core_monitor_valid(core_monitor_valid),
      .monitor_clk_rc_select(rc_sel), .timing_clk_crystal(xtal), .osc_bypass_a(byp),
      .core_monitor_enable(mon_en), .core_reset_n(core_rst_n)
   );

   // System clock, 20 ns period.
   always #10 pclk = ~pclk;

   // Slow tick: five cycles high and five low, so the block never misses an edge.
   always @(posedge pclk) begin
      div <= (div == 4) ? 0 : div + 1;
      if (div == 4) begin
         slow_rc_clk <= ~slow_rc_clk;
      end
   end

   // Compare one value; unknown bits never count as a match.
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for an answer that never comes.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Register write; mapped places never answer with an error.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk($sformatf("write error %h", a), 32'h00000000, {31'h0, e});
   endtask : wr

   // Register read against an expected word and error flag.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h00000000, r, e);
      chk($sformatf("read %h", a), exp, r);
      chk($sformatf("read error %h", a), {31'h0, xe}, {31'h0, e});
   endtask : rd

   // Wait a number of slow ticks, then land just after a system edge.
   task automatic ticks(input int n);
      repeat (n) @(posedge slow_rc_clk);
      @(posedge pclk);
   endtask : ticks

   // Reset pulse of five cycles, with output levels checked while it is held.
   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      chk("reset core_reset_n", 32'h0, {31'h0, core_rst_n});
      chk("reset monitor enable", 32'h1, {31'h0, mon_en});
      chk("reset rc select", 32'h1, {31'h0, rc_sel});
      presetn <= 1'b1;
      ticks(2);
      chk("core_reset_n released", 32'h1, {31'h0, core_rst_n});
   endtask : do_reset

   // Closing report and verdict.
   task automatic results();
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   // Watchdog: the whole sequence needs far fewer cycles than this.
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      results();
   end

   // Main sequence.
   initial begin
      do_reset();
      rd(`SCR_OFS_MODE, 32'h00000000, 1'b0);
      rd(`SCR_OFS_STAT, 32'h00000000, 1'b0);
      rd(`SCR_OFS_PWR, 32'h00000000, 1'b0);
      rd(`SCR_OFS_CTRL, 32'h00000000, 1'b0);
      rd(8'h0C, 32'h00000000, 1'b1);
      // Wrong keys: neither a crystal request nor a mode write may act.
      wr(`SCR_OFS_CTRL, 32'h5A000008);
      wr(`SCR_OFS_MODE, 32'h5A001000);
      rd(`SCR_OFS_MODE, 32'h00000000, 1'b0);
      wr(`SCR_OFS_MODE, 32'hA5001F0F);
      rd(`SCR_OFS_MODE, 32'h00001000, 1'b0);
      // Supply loss with reset enabled: one event, a core reset, delayed clear.
      core_monitor_valid <= 1'b0;
      ticks(3);
      chk("core_reset_n on loss", 32'h0, {31'h0, core_rst_n});
      rd(`SCR_OFS_STAT, 32'h00000008, 1'b0);
      rd(`SCR_OFS_STAT, 32'h00000008, 1'b0);
      ticks(3);
      rd(`SCR_OFS_STAT, 32'h00000000, 1'b0);
      core_monitor_valid <= 1'b1;
      // Three ticks, since the first may still fall inside the loss window.
      ticks(3);
      chk("core_reset_n back", 32'h1, {31'h0, core_rst_n});
      // A disabled monitor neither flags nor resets.
      wr(`SCR_OFS_MODE, 32'hA5003000);
      // The enable pin follows the stored bit one edge after the write.
      repeat (2) @(posedge pclk);
      chk("monitor enable", 32'h0, {31'h0, mon_en});
      core_monitor_valid <= 1'b0;
      ticks(4);
      chk("core_reset_n masked", 32'h1, {31'h0, core_rst_n});
      rd(`SCR_OFS_STAT, 32'h00000000, 1'b0);
      core_monitor_valid <= 1'b1;
      wr(`SCR_OFS_MODE, 32'hA5000000);
      repeat (2) @(posedge pclk);
      chk("monitor enable back", 32'h1, {31'h0, mon_en});
      wr(`SCR_OFS_SMMR, 32'hFF7FFFFF);
      rd(`SCR_OFS_SMMR, 32'h00000000, 1'b0);
      // Write protection with a wrong and a right key.
      wr(`SCR_OFS_WPMR, 32'h52544401);
      rd(`SCR_OFS_WPMR, 32'h00000000, 1'b0);
      wr(`SCR_OFS_WPMR, 32'h52544301);
      rd(`SCR_OFS_WPMR, 32'h00000001, 1'b0);
      wr(`SCR_OFS_MODE, 32'hA5500000);
      wr(`SCR_OFS_CTRL, 32'hA5000008);
      ticks(3);
      rd(`SCR_OFS_MODE, 32'h00000000, 1'b0);
      rd(`SCR_OFS_STAT, 32'h00000000, 1'b0);
      wr(`SCR_OFS_WPMR, 32'h52544300);
      rd(`SCR_OFS_WPMR, 32'h00000000, 1'b0);
      // Fast start-up with bypass set first, as software must.
      wr(`SCR_OFS_MODE, 32'hA5500000);
      wr(`SCR_OFS_CTRL, 32'hA5000028);
      ticks(2);
      rd(`SCR_OFS_STAT, 32'h00000080, 1'b0);
      chk("crystal out", 32'h1, {31'h0, xtal});
      chk("bypass out", 32'h1, {31'h0, byp});
      chk("rc select", 32'h1, {31'h0, rc_sel});
      wr(`SCR_OFS_CTRL, 32'hA5000000);
      rd(`SCR_OFS_STAT, 32'h00000080, 1'b0);
      // Only a reset returns the source; then the long start-up count.
      do_reset();
      rd(`SCR_OFS_STAT, 32'h00000000, 1'b0);
      wr(`SCR_OFS_CTRL, 32'hA5000008);
      // A check after n ticks sees the effect of the first n-1 of them.
      ticks(2);
      chk("crystal early", 32'h0, {31'h0, xtal});
      ticks(2);
      chk("crystal before count end", 32'h0, {31'h0, xtal});
      ticks(1);
      chk("crystal at count end", 32'h1, {31'h0, xtal});
      chk("bypass unset", 32'h0, {31'h0, byp});
      rd(`SCR_OFS_STAT, 32'h00000080, 1'b0);
      results();
   end
endmodule : tb
